// ---- rtl/ind_readout_map.svh ----
`ifndef IND_READOUT_MAP_SVH
`define IND_READOUT_MAP_SVH
// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define OFF_STATUS      8'h00
`define OFF_BTN_OUT     8'h01
`define OFF_PROC_BASE   8'h02
`define OFF_PROC_LAST   8'h09
`define OFF_CHAN_EN     8'h0C
`define OFF_ALG_SEL     8'h11
`define OFF_RAW_BASE    8'h20
`define OFF_RAW_LAST    8'h2B
`define OFF_WIN_COUNT   8'h30
`define OFF_WIN_DIV     8'h34
`define OFF_SCAN_RATE   8'h35
`define OFF_THRESHOLD   8'h3A
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define FLD_ALERT_POL   0
`define FLD_ALG_SEL     1
`define FLD_DATA_RDY    4
`define FLD_LP_LO       4
`define FLD_ST_ALERT    0
`define FLD_ST_MODE     1
`define FLD_ST_MULTI    2
`define FLD_ST_LOCK     3
`define ALG_RAW         1'b0
`define RAW_BYTES       3
`define WIN_BASE_SHIFT  7
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define RST_CHAN_EN     8'h00
`define RST_ALG_SEL     8'h00
`define RST_THRESHOLD   8'h10
`define RST_WIN_COUNT   4'h0
`define RST_WIN_DIV     2'h0
`define RST_SCAN_RATE   2'h0
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_MHZ         25
`define SCAN_BASE_US    12500
`define LP_FRAME_DIV    4'hF
`endif

// ---- rtl/ind_readout_pkg.sv ----
package ind_readout_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_e;

  // complete module state
  typedef struct packed {
    seq_e              seq;
    logic [3:0]        pend;
    logic [23:0]       frame_cnt;
    logic [3:0]        lp_phase;
    logic              conv_start;
    logic [1:0]        conv_channel;
    logic [14:0]       conv_window;
    logic [1:0][25:0]  fifo;
    logic              wptr;
    logic              rptr;
    logic [1:0]        cnt;
    logic [3:0][23:0]  raw;
    logic [3:0][11:0]  proc_data;
    logic [3:0]        press;
    logic              data_ready;
    logic              alert;
    logic              lock;
    logic [7:0]        chan_en;
    logic [7:0]        alg_cfg;
    logic [7:0]        threshold;
    logic [3:0][3:0]   win_count;
    logic [1:0]        win_div;
    logic [1:0]        scan_rate;
    logic [7:0]        rdata;
    logic              rvalid;
    logic [3:0]        press_pin;
    logic              alert_oe;
  } state_s;
endpackage

// ---- rtl/ind_readout.sv ----
`timescale 1ns/1ps
`include "ind_readout_map.svh"

module ind_readout #(
  parameter int unsigned SCAN_BASE_CYCLES = `SCAN_BASE_US * `CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port (byte wide serial bus side)
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // converter core
  output logic             conv_start,
  output logic      [1:0]  conv_channel,
  output logic      [14:0] conv_window,
  input  wire logic        conv_done,
  input  wire logic [23:0] conv_count,
  // pins
  input  wire logic        low_power_select_pin,
  output logic      [3:0]  button_press_pin,
  output logic             host_alert_pin_o,
  output logic             host_alert_pin_oe
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // window length = base * (1 + count) * 2^divider
  function automatic logic [14:0] window_len(input logic [3:0] wc,
                                             input logic [1:0] dv);
    logic [4:0] w1;
    w1 = {1'b0, wc} + 5'd1;
    return 15'({w1, {`WIN_BASE_SHIFT{1'b0}}}) << dv;
  endfunction

  // lowest set bit, so channels go in ascending order
  function automatic logic [1:0] lowest(input logic [3:0] m);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // more than one channel set
  function automatic logic several(input logic [3:0] m);
    return (m & (m - 4'd1)) != 4'd0;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ind_readout_pkg::state_s state_r;    // registered state
  ind_readout_pkg::state_s state_nxt;  // next state

  logic [3:0]  lp_eff;      // low-power bits in force
  logic [3:0]  eligible;    // channels due this frame
  logic [23:0] period;      // scan period in cycles
  logic        tick;        // period boundary
  logic        fifo_drain;  // publish one result
  logic [25:0] head;        // oldest buffered result
  logic [1:0]  hch;         // its channel
  logic [11:0] diff;        // processed button value
  logic        btn_mode;    // algorithm running
  logic [7:0]  rd_mux;      // read data before register

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  always_comb begin
    btn_mode = state_r.alg_cfg[`FLD_ALG_SEL] != `ALG_RAW;
    // low-power only when normal enable is set and pin low
    lp_eff = state_r.chan_en[3:0]
           & state_r.chan_en[`FLD_LP_LO +: 4]
           & {4{~low_power_select_pin}};
    // normal channels every frame, low-power ones on slow frames
    eligible = (state_r.chan_en[3:0] & ~lp_eff)
             | (lp_eff & {4{state_r.lp_phase == 4'd0}});
    period = 24'(SCAN_BASE_CYCLES) << state_r.scan_rate;
    tick = state_r.frame_cnt >= period - 24'd1;
    fifo_drain = (state_r.cnt != 2'd0) && !state_r.lock;
    head = state_r.fifo[state_r.rptr];
    hch = head[25:24];
    diff = state_r.raw[hch][23:12] - head[23:12];
  end

  // ------------------------------------------------------------
  // register read decode
  // ------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;  // unmapped reads as zero
    if (reg_addr == `OFF_STATUS) begin
      rd_mux[`FLD_ST_ALERT] = state_r.alert;
      rd_mux[`FLD_ST_MODE]  = btn_mode;
      rd_mux[`FLD_ST_MULTI] = several(state_r.chan_en[3:0]);
      rd_mux[`FLD_ST_LOCK]  = state_r.lock;
    end else if (reg_addr == `OFF_BTN_OUT) begin
      rd_mux = {3'b000, state_r.data_ready, state_r.press};
    end else if (reg_addr >= `OFF_PROC_BASE &&
                 reg_addr <= `OFF_PROC_LAST) begin
      if (reg_addr[0]) begin
        rd_mux = {{4{state_r.proc_data[reg_addr[2:1] - 2'd1][11]}},
                  state_r.proc_data[reg_addr[2:1] - 2'd1][11:8]};
      end else begin
        rd_mux = state_r.proc_data[reg_addr[2:1] - 2'd1][7:0];
      end
    end else if (reg_addr == `OFF_CHAN_EN) begin
      rd_mux = state_r.chan_en;
    end else if (reg_addr == `OFF_ALG_SEL) begin
      rd_mux = state_r.alg_cfg;
    end else if (reg_addr >= `OFF_RAW_BASE &&
                 reg_addr <= `OFF_RAW_LAST) begin
      for (int c = 0; c < 4; c++) begin
        for (int b = 0; b < `RAW_BYTES; b++) begin
          if (reg_addr == `OFF_RAW_BASE + 8'(c * `RAW_BYTES + b)) begin
            rd_mux = state_r.raw[c][8 * (2 - b) +: 8];
          end
        end
      end
    end else if (reg_addr >= `OFF_WIN_COUNT &&
                 reg_addr < `OFF_WIN_DIV) begin
      rd_mux = {4'h0, state_r.win_count[reg_addr[1:0]]};
    end else if (reg_addr == `OFF_WIN_DIV) begin
      rd_mux = {6'b0, state_r.win_div};
    end else if (reg_addr == `OFF_SCAN_RATE) begin
      rd_mux = {6'b0, state_r.scan_rate};
    end else if (reg_addr == `OFF_THRESHOLD) begin
      rd_mux = state_r.threshold;
    end
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.conv_start = 1'b0;
    state_nxt.rvalid = reg_rd;
    state_nxt.rdata = reg_rd ? rd_mux : 8'h00;

    // frame timer and slow-frame phase
    if (tick) begin
      state_nxt.frame_cnt = 24'd0;
      state_nxt.lp_phase = state_r.lp_phase + 4'd1;
      if (state_r.lp_phase == `LP_FRAME_DIV) begin
        state_nxt.lp_phase = 4'd0;
      end
    end else begin
      state_nxt.frame_cnt = state_r.frame_cnt + 24'd1;
    end

    // sequencer: one conversion outstanding at a time
    unique case (state_r.seq)
      ind_readout_pkg::SEQ_IDLE: begin
        if (tick && eligible != 4'd0) begin
          state_nxt.pend = eligible;
          state_nxt.seq = ind_readout_pkg::SEQ_START;
        end
      end
      ind_readout_pkg::SEQ_START: begin
        // hold off while the buffer is full: no result dropped
        if (state_r.cnt != 2'd2) begin
          state_nxt.conv_start = 1'b1;
          state_nxt.conv_channel = lowest(state_r.pend);
          state_nxt.conv_window = window_len(
            state_r.win_count[lowest(state_r.pend)], state_r.win_div);
          state_nxt.seq = ind_readout_pkg::SEQ_WAIT;
        end
      end
      ind_readout_pkg::SEQ_WAIT: begin
        if (conv_done) begin
          state_nxt.pend[state_r.conv_channel] = 1'b0;
          if ((state_r.pend & ~(4'd1 << state_r.conv_channel)) != 4'd0)
          begin
            state_nxt.seq = ind_readout_pkg::SEQ_START;
          end else begin
            state_nxt.seq = ind_readout_pkg::SEQ_IDLE;
          end
        end
      end
      default: begin
        state_nxt.seq = ind_readout_pkg::SEQ_IDLE;
      end
    endcase

    // two-entry buffer, fill side (room reserved by sequencer)
    if (state_r.seq == ind_readout_pkg::SEQ_WAIT && conv_done) begin
      state_nxt.fifo[state_r.wptr] = {state_r.conv_channel, conv_count};
      state_nxt.wptr = ~state_r.wptr;
    end

    // host side clears first, so hardware sets below win
    if (reg_rd && reg_addr == `OFF_STATUS) begin
      state_nxt.alert = 1'b0;
      state_nxt.lock = 1'b1;
    end
    if (reg_rd && reg_addr == `OFF_BTN_OUT) begin
      state_nxt.data_ready = 1'b0;
    end
    if (reg_rd && (reg_addr == `OFF_RAW_LAST ||
                   reg_addr == `OFF_PROC_LAST)) begin
      state_nxt.lock = 1'b0;
    end

    // drain side: publish the oldest result
    if (fifo_drain) begin
      state_nxt.rptr = ~state_r.rptr;
      state_nxt.raw[hch] = head[23:0];
      state_nxt.data_ready = 1'b1;
      if (btn_mode) begin
        state_nxt.proc_data[hch] = diff;
        state_nxt.press[hch] = !diff[11] &&
                               diff >= {4'h0, state_r.threshold};
        if (state_nxt.press[hch] != state_r.press[hch]) begin
          state_nxt.alert = 1'b1;
        end
      end else begin
        state_nxt.alert = 1'b1;
      end
    end
    state_nxt.cnt = state_r.cnt
                  + 2'(state_r.seq == ind_readout_pkg::SEQ_WAIT && conv_done)
                  - 2'(fifo_drain);

    // register writes
    if (reg_wr) begin
      if (reg_addr == `OFF_CHAN_EN) begin
        state_nxt.chan_en = reg_wdata;
      end else if (reg_addr == `OFF_ALG_SEL) begin
        state_nxt.alg_cfg = reg_wdata;
      end else if (reg_addr >= `OFF_WIN_COUNT &&
                   reg_addr < `OFF_WIN_DIV) begin
        state_nxt.win_count[reg_addr[1:0]] = reg_wdata[3:0];
      end else if (reg_addr == `OFF_WIN_DIV) begin
        state_nxt.win_div = reg_wdata[1:0];
      end else if (reg_addr == `OFF_SCAN_RATE) begin
        state_nxt.scan_rate = reg_wdata[1:0];
      end else if (reg_addr == `OFF_THRESHOLD) begin
        state_nxt.threshold = reg_wdata;
      end
    end

    // raw mode leaves press pins idle; open-drain polarity
    state_nxt.press_pin = btn_mode ? state_nxt.press : 4'h0;
    state_nxt.alert_oe = state_nxt.alert
                       ^ state_nxt.alg_cfg[`FLD_ALERT_POL];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
      state_r.seq <= ind_readout_pkg::SEQ_IDLE;
      state_r.chan_en <= `RST_CHAN_EN;
      state_r.alg_cfg <= `RST_ALG_SEL;
      state_r.threshold <= `RST_THRESHOLD;
      state_r.win_count <= {4{`RST_WIN_COUNT}};
      state_r.win_div <= `RST_WIN_DIV;
      state_r.scan_rate <= `RST_SCAN_RATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flops; alert drive value tied low
  // ------------------------------------------------------------
  assign reg_rdata = state_r.rdata;
  assign reg_rvalid = state_r.rvalid;
  assign conv_start = state_r.conv_start;
  assign conv_channel = state_r.conv_channel;
  assign conv_window = state_r.conv_window;
  assign button_press_pin = state_r.press_pin;
  assign host_alert_pin_o = 1'b0;  // open drain only pulls low
  assign host_alert_pin_oe = state_r.alert_oe;

endmodule // ind_readout

// ---- sim/ind_readout_assertions.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------
// port checker for the readout block
// ---------------------------------------------------
module ind_readout_checker #(
  parameter int unsigned SCAN_BASE_CYCLES = 50
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        conv_start,
  input wire logic [1:0]  conv_channel,
  input wire logic [14:0] conv_window,
  input wire logic        conv_done,
  input wire logic [23:0] conv_count,
  input wire logic        low_power_select_pin,
  input wire logic [3:0]  button_press_pin,
  input wire logic        host_alert_pin_o,
  input wire logic        host_alert_pin_oe
);
  logic [3:0]      en_r;   // channel enables as written
  logic            alg_r;  // button mode selected
  logic            pol_r;  // alert polarity
  logic            lock_r; // snapshot held by host
  logic [3:0][3:0] wc_r;   // window counts
  logic [1:0]      div_r;  // window divider exponent
  int unsigned     calm_r; // cycles since enables changed
  // shadow of the config; enables settle after pending starts drain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r   <= 4'h0;
      alg_r  <= 1'b0;
      pol_r  <= 1'b0;
      lock_r <= 1'b0;
      wc_r   <= 16'h0000;
      div_r  <= 2'h0;
      calm_r <= 0;
    end else begin
      calm_r <= calm_r + 1;
      if (reg_wr && reg_addr == 8'h0C) begin
        en_r   <= reg_wdata[3:0];
        calm_r <= 0;
      end
      if (reg_wr && reg_addr == 8'h11) begin
        pol_r <= reg_wdata[0];
        alg_r <= reg_wdata[1];
      end
      if (reg_wr && reg_addr[7:2] == 6'h0C)
        wc_r[reg_addr[1:0]] <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 8'h34)
        div_r <= reg_wdata[1:0];
      if (reg_rd && reg_addr == 8'h00)
        lock_r <= 1'b1;
      if (reg_rd && (reg_addr == 8'h2B || reg_addr == 8'h09))
        lock_r <= 1'b0;
    end
  end
  // ---------------------------------------------------
  // properties
  // ---------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence status_read;
    reg_rd && reg_addr == 8'h00;
  endsequence
  sequence fresh_raw;
    conv_done && !alg_r && !pol_r && !lock_r &&
      !(reg_rd && reg_addr == 8'h00);
  endsequence
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start wider than one cycle");
  chan_hold_a: assert property (
    !conv_start |-> $stable(conv_channel) && $stable(conv_window))
    else $error("channel or window moved without start");
  en_chan_a: assert property (
    conv_start && calm_r > 2 * SCAN_BASE_CYCLES |-> en_r[conv_channel])
    else $error("start on a disabled channel");
  window_a: assert property (
    conv_start |-> conv_window ==
      ((15'h0001 + 15'(wc_r[conv_channel])) << (7 + div_r)))
    else $error("window length off");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data outside answer");
  alert_raise_a: assert property (
    fresh_raw |-> ##[1:4] host_alert_pin_oe)
    else $error("no alert on new raw data");
  alert_clear_a: assert property (
    status_read ##0 (!pol_r && !conv_done && !$past(conv_done))
      |=> !host_alert_pin_oe)
    else $error("alert kept after status read");
  raw_nopress_a: assert property (
    !alg_r [*3] |-> button_press_pin == 4'h0)
    else $error("press output in raw mode");
endmodule // ind_readout_checker

bind ind_readout ind_readout_checker #(
  .SCAN_BASE_CYCLES(SCAN_BASE_CYCLES)
) ind_readout_checker_inst (
  .clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_rvalid, .conv_start, .conv_channel,
  .conv_window, .conv_done, .conv_count, .low_power_select_pin,
  .button_press_pin, .host_alert_pin_o, .host_alert_pin_oe);

// ---- sim/conv_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------
// converter stand-in, one conversion at a time
// ---------------------------------------------------
module conv_model #(
  parameter int DELAY = 5  // cycles from start to result
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        conv_start,
  input  wire logic [1:0]  conv_channel,
  input  wire logic [23:0] dip,
  output logic             conv_done,
  output logic      [23:0] conv_count
);
  int         left_r; // cycles to result, 0 when idle
  logic [1:0] ch_r;   // channel in conversion
  // count valid only with done; inverted otherwise so no late
  // sampler can get lucky
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_r     <= 0;
      ch_r       <= 2'h0;
      conv_done  <= 1'b0;
      conv_count <= 24'h00_0000;
    end else begin
      conv_done  <= 1'b0;
      conv_count <= ~conv_count;
      if (conv_start) begin
        left_r <= DELAY;
        ch_r   <= conv_channel;
      end else if (left_r == 1) begin
        left_r     <= 0;
        conv_done  <= 1'b1;
        conv_count <= 24'h40_0000 + 24'(ch_r) * 24'h01_0101 - dip;
      end else if (left_r > 1) begin
        left_r <= left_r - 1;
      end
    end
  end
endmodule // conv_model

// ---- sim/test_ind_readout.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------
// bench for the readout block
// ---------------------------------------------------
module test_ind_readout;
  localparam int BASE  = 50;    // short scan period
  localparam int LIMIT = 20000; // cycle ceiling
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        conv_start;
  logic [1:0]  conv_channel;
  logic [14:0] conv_window;
  logic        conv_done;
  logic [23:0] conv_count;
  logic        lp_pin = 1'b0;
  logic [3:0]  button_press_pin;
  logic        alert_o;
  logic        alert_oe;
  logic [23:0] dip = 24'h00_0000; // drop in next counts
  logic [1:0]  ch;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;
  wire logic   alert_line = alert_oe ? alert_o : 1'b1; // pull-up
  always #20 clk = ~clk;
  ind_readout #(.SCAN_BASE_CYCLES(BASE)) ind_readout_inst (
    .clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .conv_start, .conv_channel,
    .conv_window, .conv_done, .conv_count,
    .low_power_select_pin(lp_pin), .button_press_pin,
    .host_alert_pin_o(alert_o), .host_alert_pin_oe(alert_oe));
  conv_model #(.DELAY(5)) conv_model_inst (
    .clk, .reset_n, .conv_start, .conv_channel, .dip,
    .conv_done, .conv_count);
  function automatic logic [23:0] raw_exp(input logic [1:0] c);
    return 24'h40_0000 + 24'(c) * 24'h01_0101 - dip;
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
  endtask
  // read one byte and compare the masked value
  task automatic rchk(input logic [7:0] a, e, m);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    check(reg_rvalid, 1'b1);
    check(reg_rdata & m, e);
  endtask
  task automatic wait_start();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conv_start !== 1'b1 && n < 200);
    ch = conv_channel;
  endtask
  task automatic count_starts(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (conv_start === 1'b1) n++;
    end
  endtask
  // let pending starts drain before the new enables
  task automatic set_en(input logic [7:0] v);
    wr(8'h0C, 8'h00);
    repeat (120) @(negedge clk);
    wr(8'h0C, v);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    // reset values, read-only and unmapped places
    rchk(8'h0C, 8'h00, 8'hFF);
    rchk(8'h11, 8'h00, 8'hFF);
    rchk(8'h3A, 8'h10, 8'hFF);
    rchk(8'h50, 8'h00, 8'hFF);
    wr(8'h01, 8'hFF);
    rchk(8'h01, 8'h00, 8'hFF);
    // two channels in raw mode
    wr(8'h30, 8'h01);
    wr(8'h34, 8'h01);
    wr(8'h0C, 8'h05);
    wait_start();
    check(ch, 2'd0);
    check(conv_window, 15'd512);
    wait_start();
    check(ch, 2'd2);
    check(conv_window, 15'd256);
    repeat (10) @(negedge clk);
    check(alert_line, 1'b0);
    rchk(8'h00, 8'h05, 8'h07);
    check(alert_line, 1'b1);
    rchk(8'h01, 8'h10, 8'h1F);
    for (int i = 0; i < 3; i++) begin
      rchk(8'h20 + 8'(i), 8'(raw_exp(0) >> (16 - 8 * i)), 8'hFF);
      rchk(8'h26 + 8'(i), 8'(raw_exp(2) >> (16 - 8 * i)), 8'hFF);
    end
    rchk(8'h2B, 8'h00, 8'hFF);
    // lock held: buffer fills and the sequencer stalls
    wait_start();
    rchk(8'h00, 8'h04, 8'h0F);
    count_starts(300);
    check(n <= 3, 1'b1);
    rchk(8'h2B, 8'h00, 8'hFF);
    count_starts(200);
    check(n >= 4, 1'b1);
    // low-power bits and the select pin
    set_en(8'h10);
    count_starts(200);
    check(24'(n), 24'h00_0000);
    set_en(8'h11);
    count_starts(200);
    check(n <= 1, 1'b1);
    lp_pin = 1'b1;
    count_starts(200);
    check(n >= 3, 1'b1);
    // button mode: a drop in count becomes a press
    wr(8'h11, 8'h02);
    repeat (120) @(negedge clk);
    dip = 24'h02_0000;
    n = 0;
    while (button_press_pin[0] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(button_press_pin[0], 1'b1);
    rchk(8'h00, 8'h02, 8'h02);
    rchk(8'h02, 8'h20, 8'hFF);
    rchk(8'h03, 8'h00, 8'hFF);
    rchk(8'h09, 8'h00, 8'hFF);
    // active-high alert polarity: idle line now held low
    wr(8'h11, 8'h03);
    check(alert_line, 1'b0);
    n = 0;
    while (button_press_pin[0] !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(button_press_pin[0], 1'b0);
    check(alert_line, 1'b1);
    // higher threshold: a small drop is reported but not pressed
    wr(8'h3A, 8'h20);
    dip = 24'h03_0000;
    count_starts(60);
    check(button_press_pin, 4'h0);
    rchk(8'h00, 8'h03, 8'h0F);
    check(alert_line, 1'b0);
    rchk(8'h02, 8'h10, 8'hFF);
    rchk(8'h09, 8'h00, 8'hFF);
    // slower scan rate doubles the period
    wr(8'h35, 8'h01);
    rchk(8'h35, 8'h01, 8'hFF);
    count_starts(300);
    check(n >= 2 && n <= 3, 1'b1);
    wrap_up();
  end
endmodule // test_ind_readout
